// ===== include/dli_pkg.sv
// Package of register map, field positions and states for the data link interrupt enable block
`default_nettype none
package dli_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] DLI_OFS_ENABLE = 8'h00; // Interrupt enable register
  localparam logic [7:0] DLI_OFS_STATUS = 8'h04; // Event status register, cleared on read
  // Number of event sources
  localparam int DLI_NUM_EV = 7;
  // Bit positions shared by enable and status registers
  localparam int DLI_BIT_TX_BEGIN = 6;
  localparam int DLI_BIT_RX_BEGIN = 5;
  localparam int DLI_BIT_TX_DONE = 4;
  localparam int DLI_BIT_RX_DONE = 3;
  localparam int DLI_BIT_FCS = 2;
  localparam int DLI_BIT_ABORT = 1;
  localparam int DLI_BIT_IDLE = 0;
  // Reset values
  localparam logic [6:0] DLI_ENABLE_RST = 7'h00;
  localparam logic [6:0] DLI_STATUS_RST = 7'h00;
  localparam logic [31:0] DLI_RDATA_RST = 32'h00000000;
  // Mask of implemented bits, the top bit of the byte is reserved
  localparam logic [7:0] DLI_IMPL_MASK = 8'h7F;
  // Bus slave phases
  typedef enum logic [1:0] {
    DLI_ST_IDLE = 2'b00,
    DLI_ST_RESP = 2'b01
  } dli_state_t;
endpackage : dli_pkg
`default_nettype wire

// ===== include/dli_ev_if.sv
// Interface carrying event pulses and clear-on-read strobe to the status flag module
`default_nettype none
interface dli_ev_if;
  logic [6:0] event_pulse; // One-cycle event pulses from the HDLC controllers
  logic clear_strobe; // Read of the status register clears the flags
  logic [6:0] flags; // Sticky flags
  modport ctrl (output event_pulse, output clear_strobe, input flags);
  modport store (input event_pulse, input clear_strobe, output flags);
endinterface : dli_ev_if
`default_nettype wire

// ===== hw/dli_flags.sv
// Sticky event flags, set by event pulses and cleared by a status read
`default_nettype none
module dli_flags (
  input wire logic pclk,
  input wire logic presetn,
  dli_ev_if.store ev
);
  // All state of this module
  typedef struct packed {
    logic [6:0] flags_r; // Sticky event flags
  } dli_flags_state_t;

  dli_flags_state_t st_r; // Registered state
  dli_flags_state_t st_nxt; // Next state

  // Set wins over clear so that an event in the clearing cycle survives
  always_comb begin
    st_nxt = st_r;
    st_nxt.flags_r = (ev.clear_strobe ? dli_pkg::DLI_STATUS_RST : st_r.flags_r)
                     | ev.event_pulse;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{flags_r: dli_pkg::DLI_STATUS_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ev.flags = st_r.flags_r;

  // A pulse must leave its flag set in the next cycle
  chk_event_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (ev.event_pulse != 7'h00) |=> ((ev.flags & $past(ev.event_pulse)) == $past(ev.event_pulse)))
    else $error("event pulse did not set its flag");
  // A clear without events empties the flags
  chk_read_clears_flags: assert property (@(posedge pclk) disable iff (!presetn)
    (ev.clear_strobe && ev.event_pulse == 7'h00) |=> (ev.flags == 7'h00))
    else $error("status read did not clear flags");
endmodule : dli_flags
`default_nettype wire

// ===== hw/dli_top.sv
// Data link interrupt enable block with APB register access
`default_nettype none
module dli_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_message_begin,
  input wire logic rx_message_begin,
  input wire logic tx_message_done,
  input wire logic rx_message_done,
  input wire logic checksum_fault,
  input wire logic rx_abort_seen,
  input wire logic rx_idle_flag,
  output logic irq_req,
  output logic [6:0] data_link_interrupt_enable_one
);
  // All state of the top module
  typedef struct packed {
    dli_pkg::dli_state_t phase_r; // Bus slave phase
    logic [6:0] enable_r; // Interrupt enables
    logic [31:0] rdata_r; // Read data
    logic ready_r; // Access completes
    logic slverr_r; // Unmapped address
    logic irq_r; // Interrupt request
  } dli_top_state_t;

  dli_top_state_t st_r; // Registered state
  dli_top_state_t st_nxt; // Next state
  dli_ev_if ev (); // Link to the flag store
  logic setup_cyc; // APB setup phase
  logic hit_enable; // Address selects enable register
  logic hit_status; // Address selects status register
  logic [6:0] pending; // Flags gated by enables

  // Sticky status flags
  dli_flags u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .ev(ev)
  );

  // Address decode
  assign setup_cyc = psel && !penable;
  assign hit_enable = (paddr == dli_pkg::DLI_OFS_ENABLE);
  assign hit_status = (paddr == dli_pkg::DLI_OFS_STATUS);

  // Event pulses from the controllers in their bit positions
  always_comb begin
    ev.event_pulse = 7'h00;
    ev.event_pulse[dli_pkg::DLI_BIT_TX_BEGIN] = tx_message_begin;
    ev.event_pulse[dli_pkg::DLI_BIT_RX_BEGIN] = rx_message_begin;
    ev.event_pulse[dli_pkg::DLI_BIT_TX_DONE] = tx_message_done;
    ev.event_pulse[dli_pkg::DLI_BIT_RX_DONE] = rx_message_done;
    ev.event_pulse[dli_pkg::DLI_BIT_FCS] = checksum_fault;
    ev.event_pulse[dli_pkg::DLI_BIT_ABORT] = rx_abort_seen;
    ev.event_pulse[dli_pkg::DLI_BIT_IDLE] = rx_idle_flag;
  end

  // Status read clears the flags when the read data is captured in setup
  assign ev.clear_strobe = setup_cyc && !pwrite && hit_status;

  // Flags that are allowed through
  assign pending = ev.flags & st_r.enable_r;

  // Next-state logic: APB slave with one wait-free access cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.ready_r = 1'b0;
    st_nxt.slverr_r = 1'b0;
    // Request high while any enabled flag is set
    st_nxt.irq_r = |pending;
    case (st_r.phase_r)
      dli_pkg::DLI_ST_IDLE: begin
        // Setup phase: decode, prepare answer for the access phase
        if (setup_cyc) begin
          st_nxt.phase_r = dli_pkg::DLI_ST_RESP;
          st_nxt.ready_r = 1'b1;
          st_nxt.rdata_r = dli_pkg::DLI_RDATA_RST;
          if (hit_enable) begin
            if (pwrite) begin
              // Reserved bit 7 and upper lanes dropped
              st_nxt.enable_r = pwdata[6:0];
            end else begin
              st_nxt.rdata_r = {25'h0000000, st_r.enable_r};
            end
          end else if (hit_status) begin
            // Status register is read only
            if (!pwrite) begin
              st_nxt.rdata_r = {25'h0000000, ev.flags};
            end
          end else begin
            // Unmapped address answers with an error
            st_nxt.slverr_r = 1'b1;
          end
        end
      end
      dli_pkg::DLI_ST_RESP: begin
        // Access phase completes this cycle
        st_nxt.phase_r = dli_pkg::DLI_ST_IDLE;
      end
      default: begin
        st_nxt.phase_r = dli_pkg::DLI_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.phase_r <= dli_pkg::DLI_ST_IDLE;
      st_r.enable_r <= dli_pkg::DLI_ENABLE_RST;
      st_r.rdata_r <= dli_pkg::DLI_RDATA_RST;
      st_r.ready_r <= 1'b0;
      st_r.slverr_r <= 1'b0;
      st_r.irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = st_r.rdata_r;
  assign pready = st_r.ready_r;
  assign pslverr = st_r.slverr_r;
  assign irq_req = st_r.irq_r;
  assign data_link_interrupt_enable_one = st_r.enable_r;

  // Decode terms shared by the checks below
  logic enable_write_now; // Setup of a write to the enable register
  logic status_write_now; // Setup of a write to the status register
  logic unmapped_now; // Setup of an access that hits no register

  // Setup cycle terms for the checks
  assign enable_write_now = setup_cyc && pwrite && hit_enable;
  assign status_write_now = setup_cyc && pwrite && hit_status;
  assign unmapped_now = setup_cyc && !hit_enable && !hit_status;

  // Enable register write in a setup cycle
  sequence s_write_enable;
    enable_write_now;
  endsequence

  // Enable register read in a setup cycle
  sequence s_read_enable;
    setup_cyc && !pwrite && hit_enable;
  endsequence

  // Status register read in a setup cycle, which also clears the flags
  sequence s_read_status;
    setup_cyc && !pwrite && hit_status;
  endsequence

  // Flag sets on the next edge, the request rises on the edge after
  sequence s_flag_then_irq;
    ##2 irq_req;
  endsequence

  // Tx start pulse while its enable is set and not being rewritten
  sequence s_tx_begin_armed;
    tx_message_begin && st_r.enable_r[dli_pkg::DLI_BIT_TX_BEGIN] && !enable_write_now;
  endsequence

  // Rx start pulse while its enable is set and not being rewritten
  sequence s_rx_begin_armed;
    rx_message_begin && st_r.enable_r[dli_pkg::DLI_BIT_RX_BEGIN] && !enable_write_now;
  endsequence

  // Tx end pulse while its enable is set and not being rewritten
  sequence s_tx_done_armed;
    tx_message_done && st_r.enable_r[dli_pkg::DLI_BIT_TX_DONE] && !enable_write_now;
  endsequence

  // Rx end pulse while its enable is set and not being rewritten
  sequence s_rx_done_armed;
    rx_message_done && st_r.enable_r[dli_pkg::DLI_BIT_RX_DONE] && !enable_write_now;
  endsequence

  // Checksum fault pulse while its enable is set and not being rewritten
  sequence s_fcs_armed;
    checksum_fault && st_r.enable_r[dli_pkg::DLI_BIT_FCS] && !enable_write_now;
  endsequence

  // Abort pulse while its enable is set and not being rewritten
  sequence s_abort_armed;
    rx_abort_seen && st_r.enable_r[dli_pkg::DLI_BIT_ABORT] && !enable_write_now;
  endsequence

  // Idle flag pulse while its enable is set and not being rewritten
  sequence s_idle_armed;
    rx_idle_flag && st_r.enable_r[dli_pkg::DLI_BIT_IDLE] && !enable_write_now;
  endsequence

  // Request follows enabled flags one cycle later
  chk_irq_follows_pending: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (irq_req == $past(|pending)))
    else $error("interrupt request does not track enabled flags");

  // Written enable value appears after the setup edge
  chk_enable_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_enable |=> (data_link_interrupt_enable_one == $past(pwdata[6:0])))
    else $error("enable write lost");

  // Reserved and upper bits always read zero
  chk_reserved_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> (prdata[31:7] == 25'h0000000))
    else $error("reserved bits read nonzero");

  // Tx start with its enable set raises the request
  chk_tx_begin_irq: assert property (@(posedge pclk) disable iff (!presetn)
    s_tx_begin_armed |-> s_flag_then_irq)
    else $error("tx start did not interrupt");

  // Rx start with its enable set raises the request
  chk_rx_begin_irq: assert property (@(posedge pclk) disable iff (!presetn)
    s_rx_begin_armed |-> s_flag_then_irq)
    else $error("rx start did not interrupt");

  // Tx end with its enable set raises the request
  chk_tx_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
    s_tx_done_armed |-> s_flag_then_irq)
    else $error("tx end did not interrupt");

  // Rx end with its enable set raises the request
  chk_rx_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
    s_rx_done_armed |-> s_flag_then_irq)
    else $error("rx end did not interrupt");

  // Checksum fault with its enable set raises the request
  chk_fcs_irq: assert property (@(posedge pclk) disable iff (!presetn)
    s_fcs_armed |-> s_flag_then_irq)
    else $error("checksum fault did not interrupt");

  // Abort sequence with its enable set raises the request
  chk_abort_irq: assert property (@(posedge pclk) disable iff (!presetn)
    s_abort_armed |-> s_flag_then_irq)
    else $error("abort did not interrupt");

  // Idle flag with its enable set raises the request
  chk_idle_irq: assert property (@(posedge pclk) disable iff (!presetn)
    s_idle_armed |-> s_flag_then_irq)
    else $error("idle flag did not interrupt");

  // With all enables clear no request appears
  chk_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.enable_r == 7'h00) |=> !irq_req)
    else $error("request with all enables clear");

  // Every access is answered in the cycle after setup
  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    setup_cyc |=> pready)
    else $error("apb access not answered");

  // The answer stands for a single cycle
  chk_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");

  // Enable read returns the register value of the setup cycle
  chk_enable_read_data: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_enable |=> (prdata[6:0] == $past(data_link_interrupt_enable_one)))
    else $error("enable read data wrong");

  // Status read returns the flags as they stood before the clear
  chk_status_read_data: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_status |=> (prdata[6:0] == $past(ev.flags)))
    else $error("status read data wrong");

  // Enables change only through a write to their register
  chk_enable_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !enable_write_now |=> $stable(data_link_interrupt_enable_one))
    else $error("enable changed without a write");

  // Writing the status register neither clears nor sets flags
  chk_status_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    status_write_now |=> (ev.flags == ($past(ev.flags) | $past(ev.event_pulse))))
    else $error("status write changed flags");

  // An address with no register answers with an error
  chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    unmapped_now |=> pslverr)
    else $error("unmapped access without error");

  // A mapped access answers without an error
  chk_mapped_no_error: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_cyc && !unmapped_now) |=> !pslverr)
    else $error("mapped access flagged an error");
endmodule : dli_top
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the data link interrupt enable block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0; // Bus clock, 100 MHz
  logic presetn = 1'b0; // Asynchronous reset, active low
  logic psel = 1'b0; // APB select
  logic penable = 1'b0; // APB access phase
  logic pwrite = 1'b0; // APB direction
  logic [7:0] paddr = 8'h00; // APB byte address
  logic [31:0] pwdata = 32'h00000000; // APB write data
  logic [31:0] prdata; // APB read data
  logic pready; // APB answer
  logic pslverr; // APB error
  logic [6:0] ev = 7'h00; // Event pulses, indexed by field position
  logic irq_req; // Interrupt request
  logic [6:0] en_out; // Enable register value
  logic [31:0] q; // Last read data
  logic e; // Last error flag
  int miscompares = 0; // Mismatch count
  int checked = 0; // Comparison count
  int cycles = 0; // Timeout counter
  // Device under test
  dli_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_message_begin(ev[dli_pkg::DLI_BIT_TX_BEGIN]),
    .rx_message_begin(ev[dli_pkg::DLI_BIT_RX_BEGIN]),
    .tx_message_done(ev[dli_pkg::DLI_BIT_TX_DONE]),
    .rx_message_done(ev[dli_pkg::DLI_BIT_RX_DONE]),
    .checksum_fault(ev[dli_pkg::DLI_BIT_FCS]), .rx_abort_seen(ev[dli_pkg::DLI_BIT_ABORT]),
    .rx_idle_flag(ev[dli_pkg::DLI_BIT_IDLE]), .irq_req(irq_req),
    .data_link_interrupt_enable_one(en_out)
  );
  // Clock generator
  always #5 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  // Compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Print counts and verdict, then stop
  task automatic end_of_test();
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Pulse one event and sample the request two edges after the flag sets
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev <= 7'h00;
    repeat (2) @(posedge pclk);
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(en_out, 32'h0);
    chk(irq_req, 32'h0);
    apb(1'b0, dli_pkg::DLI_OFS_ENABLE, 32'h0);
    chk(q, 32'h0);
    chk(e, 32'h0);
    apb(1'b1, dli_pkg::DLI_OFS_ENABLE, 32'hFFFFFFFF);
    apb(1'b0, dli_pkg::DLI_OFS_ENABLE, 32'h0);
    chk(q, 32'h0000007F);
    apb(1'b0, 8'h08, 32'h0);
    chk(e, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, dli_pkg::DLI_OFS_STATUS, 32'hFFFFFFFF);
    chk(e, 32'h0);
    apb(1'b0, dli_pkg::DLI_OFS_STATUS, 32'h0);
    chk(q, 32'h0);
    chk(en_out, 32'h7F);
    $display("test reset and access done");
    for (int i = 0; i < dli_pkg::DLI_NUM_EV; i++) begin
      apb(1'b1, dli_pkg::DLI_OFS_ENABLE, 32'h1 << i);
      chk(en_out, 32'h1 << i);
      pulse(i);
      chk(irq_req, 32'h1);
      apb(1'b0, dli_pkg::DLI_OFS_STATUS, 32'h0);
      chk(q, 32'h1 << i);
      apb(1'b0, dli_pkg::DLI_OFS_STATUS, 32'h0);
      chk(q, 32'h0);
      chk(irq_req, 32'h0);
      apb(1'b1, dli_pkg::DLI_OFS_ENABLE, ~(32'h1 << i));
      pulse(i);
      chk(irq_req, 32'h0);
      apb(1'b1, dli_pkg::DLI_OFS_ENABLE, 32'h7F);
      repeat (2) @(posedge pclk);
      chk(irq_req, 32'h1);
      apb(1'b1, dli_pkg::DLI_OFS_ENABLE, 32'h0);
      chk(irq_req, 32'h0);
      apb(1'b0, dli_pkg::DLI_OFS_STATUS, 32'h0);
      chk(q, 32'h1 << i);
    end
    $display("test event gating done");
    // Event in the very cycle of the clearing read: the set wins
    ev[dli_pkg::DLI_BIT_IDLE] <= 1'b1;
    fork
      apb(1'b0, dli_pkg::DLI_OFS_STATUS, 32'h0);
      begin
        @(posedge pclk);
        ev <= 7'h00;
      end
    join
    chk(q, 32'h0);
    apb(1'b0, dli_pkg::DLI_OFS_STATUS, 32'h0);
    chk(q, 32'h1 << dli_pkg::DLI_BIT_IDLE);
    $display("test clear race done");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
